// *** logic/pccs_core.sv ***
// Behaviour
// - The counter is 13 bits wide and its low byte is a software read/write register.
// - The upper five counter bits read back through the full-counter register but are never written from the bus; software loads them via the latch.
// - Every reset clears the whole counter to zero.
// - A write to the low byte loads latch bits 4..0 into the upper counter bits at once.
// - Calls and jumps take latch bits 4..3 as the top two bits, the rest from the opcode.
// - An eight-entry, 13-bit return stack lives outside program and data space.
// - The stack pointer is not reachable by software.
// - Calls push the counter plus one; interrupt vectoring pushes the current counter value.
// - All three return kinds pop the stack into the counter.
// - Pushes and pops never alter the high latch.
// - The stack is circular; the ninth push overwrites the first.
// - No flag reports overflow or underflow.
//
// Local design decisions: the register offsets and register access over Wishbone.
`include "pccs_map.svh"
`default_nettype none
module pccs_core
  import pccs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Decoder sequencing
  input  wire logic        step_i,
  input  wire pccs_op_t    op_i,
  input  wire logic [10:0] target_i,
  input  wire logic        core_low_we_i,
  input  wire logic [7:0]  core_low_dat_i,
  input  wire logic [12:0] int_vector_i,
  // Fetch address
  output logic      [12:0] instruction_pointer_o
);

  // Counter, latch and pointer state
  logic [12:0] pc_q;
  logic [12:0] pc_d;
  logic [4:0]  latch_q;
  logic [4:0]  latch_d;
  logic [2:0]  sp_q;
  logic [2:0]  sp_d;
  logic [12:0] stack_q [0:7];
  // Bus answer state
  logic        ack_q;
  logic        ack_d;
  logic        err_q;
  logic        err_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;

  // Push decode, shared by the pointer and the stack slots
  function automatic logic op_pushes(input pccs_op_t op);
    op_pushes = (op == PCCS_OP_CALL) || (op == PCCS_OP_INT);
  endfunction : op_pushes

  // Pop decode; every return kind reaches us as the one code
  function automatic logic op_pops(input pccs_op_t op);
    op_pops = (op == PCCS_OP_RET);
  endfunction : op_pops

  // Bus request is taken only when no answer is pending, so that each
  // request gets exactly one single-cycle answer even if stb stays up
  wire       req     = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  wire       hit_low = (wb_adr_i == `PCCS_OFF_LOW);
  wire       hit_lat = (wb_adr_i == `PCCS_OFF_LATCH);
  wire       hit_cnt = (wb_adr_i == `PCCS_OFF_COUNT);
  wire       mapped  = hit_low | hit_lat | hit_cnt;
  // The full counter is read-only; a write there is refused with err,
  // so the upper counter bits can never be set straight from the bus
  wire       good    = mapped & ~(wb_we_i & hit_cnt);
  wire       bus_low = req & good & wb_we_i & hit_low & wb_sel_i[0];
  wire       bus_lat = req & good & wb_we_i & hit_lat & wb_sel_i[0];
  wire       low_we  = bus_low | core_low_we_i;
  // Bus write beats the core when both hit the low byte in one cycle;
  // the core should never do this, and the bus is the easier to debug
  wire [7:0] low_val = bus_low ? wb_dat_i[7:0] : core_low_dat_i;

  // Sequencing decode; HOLD or an unknown code moves nothing
  wire        do_push  = step_i & op_pushes(op_i);
  wire        do_pop   = step_i & op_pops(op_i);
  wire [2:0]  sp_inc   = sp_q + 3'h1;
  wire [2:0]  sp_dec   = sp_q - 3'h1;
  wire [12:0] pc_inc   = pc_q + 13'h0001;
  // Only the two top bits come from the latch; bits 10..0 are the opcode's
  wire [12:0] far_tgt  = {latch_q[4:3], target_i};
  // A low-byte load takes all five latch bits; the byte gives no carry
  wire [12:0] low_tgt  = {latch_q, low_val};
  // Calls return to the next instruction; an interrupt returns to the
  // one it displaced, so the core steps in before incrementing
  wire [12:0] push_val = (op_i == PCCS_OP_CALL) ? pc_inc : pc_q;
  // Top of stack as a pop sees it
  wire [12:0] pop_val  = stack_q[sp_dec];

  // Read data; narrow registers sit in the low bits, the rest reads zero
  wire [31:0] rd_mux = hit_low ? {24'h000000, pc_q[7:0]} :
                       hit_lat ? {27'h0000000, latch_q}  :
                       {19'h00000, pc_q};

  // Next counter; a low-byte write has priority over sequencing, but a
  // push or pop in that same cycle still moves the stack
  always_comb begin
    pc_d = pc_q;
    if (low_we) begin
      pc_d = low_tgt;
    end else if (step_i) begin
      case (op_i)
        PCCS_OP_NEXT: pc_d = pc_inc;
        PCCS_OP_CALL: pc_d = far_tgt;
        PCCS_OP_JUMP: pc_d = far_tgt;
        PCCS_OP_RET:  pc_d = pop_val;
        PCCS_OP_INT:  pc_d = int_vector_i;
        default:      pc_d = pc_q;
      endcase
    end
  end

  // Latch next value; only a bus write moves it, never the stack
  always_comb begin
    latch_d = latch_q;
    if (bus_lat) begin
      latch_d = wb_dat_i[4:0];
    end
  end

  // Pointer next value; it wraps silently both ways, so software that
  // nests deeper than eight loses its oldest return points unwarned
  always_comb begin
    sp_d = sp_q;
    if (do_push) begin
      sp_d = sp_inc;
    end else if (do_pop) begin
      sp_d = sp_dec;
    end
  end

  // Bus answer next values; read data is zero outside an answer
  always_comb begin
    ack_d  = req & good;
    err_d  = req & ~good;
    rdat_d = (req & good & ~wb_we_i) ? rd_mux : 32'h00000000;
  end

  // Counter register, cleared by every reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc_q <= `PCCS_CNT_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // High latch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      latch_q <= `PCCS_LATCH_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Circular pointer, kept off the bus entirely
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sp_q <= 3'h0;
    end else begin
      sp_q <= sp_d;
    end
  end

  // Stack slots, outside every addressable space; contents are not
  // reset, so a pop past what was pushed returns an older entry
  genvar gi;
  generate
    for (gi = 0; gi < `PCCS_DEPTH; gi++) begin : g_slot
      always_ff @(posedge clk_sys) begin
        if (do_push && (sp_q == 3'(gi))) begin
          stack_q[gi] <= push_val;
        end
      end
    end
  endgenerate

  // Bus answer registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q  <= ack_d;
      err_q  <= err_d;
      rdat_q <= rdat_d;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o              = ack_q;
  assign wb_err_o              = err_q;
  assign wb_dat_o              = rdat_q;
  assign instruction_pointer_o = pc_q;

  // Steps of a call followed by its return
  sequence s_call;
    step_i && !low_we && op_i == PCCS_OP_CALL;
  endsequence
  sequence s_idle;
    !step_i && !low_we;
  endsequence
  sequence s_ret;
    step_i && !low_we && op_i == PCCS_OP_RET;
  endsequence

  // Checks on the counter
  a_reset_clears_pc: assert property (@(posedge clk_sys) srst |=> pc_q == 13'h0000)
    else $error("counter not cleared by reset");
  a_low_load_full: assert property (@(posedge clk_sys) disable iff (srst)
    low_we |=> pc_q == {$past(latch_q), $past(low_val)})
    else $error("low byte write did not load latch");
  a_jump_top_bits: assert property (@(posedge clk_sys) disable iff (srst)
    (step_i && !low_we && op_i == PCCS_OP_JUMP) |=>
      pc_q == {$past(latch_q[4:3]), $past(target_i)})
    else $error("jump target wrong");
  a_call_top_bits: assert property (@(posedge clk_sys) disable iff (srst)
    s_call |=> pc_q == {$past(latch_q[4:3]), $past(target_i)})
    else $error("call target wrong");
  a_next_increments: assert property (@(posedge clk_sys) disable iff (srst)
    (step_i && !low_we && op_i == PCCS_OP_NEXT) |=> pc_q == $past(pc_q) + 13'h0001)
    else $error("counter did not advance");
  a_int_loads_vector: assert property (@(posedge clk_sys) disable iff (srst)
    (step_i && !low_we && op_i == PCCS_OP_INT) |=> pc_q == $past(int_vector_i))
    else $error("vector not loaded");
  a_idle_keeps_pc: assert property (@(posedge clk_sys) disable iff (srst)
    (!step_i && !low_we) |=> $stable(pc_q))
    else $error("counter moved without cause");

  // Checks on the stack
  a_call_ret_pair: assert property (@(posedge clk_sys) disable iff (srst)
    (s_call ##1 s_idle ##1 s_ret) |=> pc_q == $past(pc_q, 3) + 13'h0001)
    else $error("return did not restore counter");
  a_push_moves_sp: assert property (@(posedge clk_sys) disable iff (srst)
    do_push |=> sp_q == $past(sp_q) + 3'h1)
    else $error("push pointer wrong");
  a_pop_moves_sp: assert property (@(posedge clk_sys) disable iff (srst)
    (do_pop && !do_push) |=> sp_q == $past(sp_q) - 3'h1)
    else $error("pop pointer wrong");
  a_latch_kept_stack: assert property (@(posedge clk_sys) disable iff (srst)
    ((do_push || do_pop) && !bus_lat) |=> $stable(latch_q))
    else $error("stack op changed latch");
  a_int_push_value: assert property (@(posedge clk_sys) disable iff (srst)
    (step_i && op_i == PCCS_OP_INT) |=> stack_q[$past(sp_q)] == $past(pc_q))
    else $error("interrupt push wrong");
  a_call_push_value: assert property (@(posedge clk_sys) disable iff (srst)
    (step_i && op_i == PCCS_OP_CALL) |=> stack_q[$past(sp_q)] == $past(pc_q) + 13'h0001)
    else $error("call push wrong");

  // Checks on the bus answer
  a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (srst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_err_excl: assert property (@(posedge clk_sys) disable iff (srst)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_read_upper_zero: assert property (@(posedge clk_sys) disable iff (srst)
    wb_ack_o |-> wb_dat_o[31:13] == 19'h00000)
    else $error("unused read bits not zero");

endmodule : pccs_core
`default_nettype wire

// *** logic/pccs_map.svh ***
`ifndef PCCS_MAP_SVH
`define PCCS_MAP_SVH
// Register byte offsets on the bus
`define PCCS_OFF_LOW      8'h00
`define PCCS_OFF_LATCH    8'h04
`define PCCS_OFF_COUNT    8'h08
// Field layout
`define PCCS_CNT_W        13
`define PCCS_LATCH_W      5
`define PCCS_DEPTH        8
`define PCCS_SP_W         3
// Reset values
`define PCCS_CNT_RST      13'h0000
`define PCCS_LATCH_RST    5'h00
`endif

// *** logic/pccs_pkg.sv ***
`default_nettype none
package pccs_pkg;
  // Counter sequencing operation from the decoder
  typedef enum logic [2:0] {
    PCCS_OP_NEXT = 3'h0,
    PCCS_OP_CALL = 3'h1,
    PCCS_OP_JUMP = 3'h2,
    PCCS_OP_RET  = 3'h3,
    PCCS_OP_INT  = 3'h4,
    PCCS_OP_HOLD = 3'h5
  } pccs_op_t;
endpackage : pccs_pkg
`default_nettype wire

// *** testbench/pccs_dec_model.sv ***
`default_nettype none
module pccs_dec_model
  import pccs_pkg::*;
(
  // Core clock
  input  wire logic        clk_sys,
  // Step and low-byte write toward the counter
  output var  logic        step_o,
  output var  pccs_op_t    op_o,
  output var  logic [10:0] tgt_o,
  output var  logic        we_o,
  output var  logic [7:0]  dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle decoder between steps
  initial begin
    step_o = 1'b0;
    op_o = PCCS_OP_HOLD;
    tgt_o = 11'h000;
    we_o = 1'b0;
    dat_o = 8'h00;
  end
  // One instruction per call; returns at a falling edge so results have settled
  task automatic issue(input logic s, input pccs_op_t o, input logic [10:0] t,
                       input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    step_o <= s;
    op_o <= o;
    tgt_o <= t;
    we_o <= w;  // No carry expected into upper bits; software bumps the latch
    dat_o <= d;
    @(posedge clk_sys);
    step_o <= 1'b0;
    we_o <= 1'b0;
    @(negedge clk_sys);
  endtask : issue
endmodule : pccs_dec_model
`default_nettype wire

// *** testbench/testbench.sv ***
`default_nettype none
module testbench;
  import pccs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, srst = 1'b1, req = 1'b0, we = 1'b0, ack, err, step, cwe, er;
  logic [7:0] adr = 8'h00, cdat;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [12:0] ip, pc, vec = 13'h0004, stk [8];
  logic [10:0] tgt;
  logic [4:0] lat;
  logic [2:0] sp = 3'h0;
  pccs_op_t op;
  int fails = 0, compares = 0;
  // 50 MHz core clock
  always #10 clk_sys = ~clk_sys;
  pccs_dec_model dec (.clk_sys(clk_sys), .step_o(step), .op_o(op), .tgt_o(tgt),
    .we_o(cwe), .dat_o(cdat));
  pccs_core uut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .step_i(step), .op_i(op), .target_i(tgt),
    .core_low_we_i(cwe), .core_low_dat_i(cdat), .int_vector_i(vec),
    .instruction_pointer_o(ip));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle; request held until ack or err is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1 && err !== 1'b1);
    rd = rdat;
    er = err;
    req <= 1'b0;
  endtask : wb
  // Reference stack kept here, wrapping modulo eight like the hardware
  task automatic go(input pccs_op_t o, input logic [10:0] t);
    if (o == PCCS_OP_CALL || o == PCCS_OP_INT) begin
      stk[sp] = (o == PCCS_OP_CALL) ? pc + 13'h0001 : pc;
      sp++;
    end
    if (o == PCCS_OP_RET) begin
      sp--;
      pc = stk[sp];
    end
    else if (o == PCCS_OP_INT) pc = vec;
    else if (o == PCCS_OP_NEXT) pc = pc + 13'h0001;
    else pc = {lat[4:3], t};
    dec.issue(1'b1, o, t, 1'b0, 8'h00);
    chk(32'(ip), 32'(pc));
  endtask : go
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Watchdog well beyond the hundred or so cycles the sequence needs
  initial begin
    #200us;
    fails++;
    test_done;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
    chk(32'(ip), 32'h0);
    wb(1'b1, 8'h04, 32'h1F);
    wb(1'b1, 8'h00, 32'h34);
    lat = 5'h1F;
    pc = 13'h1F34;
    chk(32'(ip), 32'(pc));
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h34);
    wb(1'b1, 8'h08, 32'h0);
    chk(32'(er), 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'(pc));
    wb(1'b0, 8'h0C, 32'h0);
    chk(32'(er), 32'h1);
    wb(1'b1, 8'h04, 32'h0B);
    lat = 5'h0B;
    for (int i = 0; i < 9; i++) go(PCCS_OP_CALL, 11'h100 + 11'(i));
    go(PCCS_OP_INT, 11'h0);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'(lat));
    for (int i = 0; i < 10; i++) go(PCCS_OP_RET, 11'h0);
    go(PCCS_OP_JUMP, 11'h7FF);
    go(PCCS_OP_NEXT, 11'h0);
    go(PCCS_OP_CALL, 11'h055);
    go(PCCS_OP_RET, 11'h0);
    dec.issue(1'b0, PCCS_OP_HOLD, 11'h0, 1'b1, 8'hFF);
    chk(32'(ip), {19'h0, lat, 8'hFF});
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
    chk(32'(ip), 32'h0);
    test_done;
  end
endmodule : testbench
`default_nettype wire
